//--- src/watchdog_powerdown_keys_defs.vh
/*
  Constants of the supervision timer with two-key command scheme:
  I/O addresses, field positions, reset values, command codes, timing.
  Assumes an 8-bit I/O space decoded on the full address.
*/
`ifndef WATCHDOG_POWERDOWN_KEYS_DEFS_VH
`define WATCHDOG_POWERDOWN_KEYS_DEFS_VH

`define ADDR_MASTER_CONTROL 8'hF0
`define ADDR_KEY_COMMAND 8'hF1

`define ENABLE_BIT 7
`define PERIOD_HI 6
`define PERIOD_LO 5
`define SLEEP_HI 1
`define SLEEP_LO 0

`define ENABLE_RESET 1'b1
`define PERIOD_RESET 2'h3
`define SLEEP_RESET 2'h3
`define RESERVED_READ 3'h3
`define KEY_READ 8'h00

`define KEY_DISABLE 8'h41
`define KEY_MODE_CHANGE 8'hDB
`define KEY_CLEAR 8'h03

`define MODE_FIRST_IDLE_MODE 2'h0
`define MODE_SECOND_IDLE_MODE 2'h1
`define MODE_STOP 2'h2
`define MODE_RUN 2'h3

`define CLOCK_PERIOD_NS 5
`define RESET_PULSE_NS 5000000
`define RESET_PULSE_CYCLES (`RESET_PULSE_NS / `CLOCK_PERIOD_NS)

`define PERIOD_CYCLES_0 32'h0001_0000
`define PERIOD_CYCLES_1 32'h0004_0000
`define PERIOD_CYCLES_2 32'h0010_0000
`define PERIOD_CYCLES_3 32'h0040_0000

`endif

//--- src/watchdog_powerdown_keys.v
/*
  Supervision timer with a two-key command scheme and the power-down
  clock gating selected for the HALT state.
  Assumes the CPU I/O strobes come from logic on CLOCK, one cycle each,
  and the halt status is on CLOCK too; the reset-wiring strap is a pin.
*/
// Functional notes
// - Master control decoded at F0H, key command at F1H.
// - Enable bit is bit 7; timing runs while it is 1.
// - Enable bit is 1 after reset, supervision starts unaided.
// - Timeout period field bits 6-5 selects interval, resets to 11.
// - Disable needs enable written 0, then the disable key.
// - Sleep mode changes only on master write right after key DBH.
// - Clear code restarts interval and withdraws a pending timeout.
// - Sleep mode 00 first_idle_mode, 01 second_idle_mode, 10 stop, 11 run; resets 11.
// - Three reserved master bits always read 011.
// - Key command register is write-only; reads return no command.
// - Enabled timer drives timeout output low when interval elapses.
// - Not wired to reset: output held low until software clears.
// - Counting suspended in idle or stop modes during halt.
// - Second_idle_mode keeps oscillator, counter/timer, clock out; stops the rest.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_powerdown_keys_defs.vh"

module watchdog_powerdown_keys #(
  parameter [31:0] PERIOD_CYCLES_0 = `PERIOD_CYCLES_0,
  parameter [31:0] PERIOD_CYCLES_1 = `PERIOD_CYCLES_1,
  parameter [31:0] PERIOD_CYCLES_2 = `PERIOD_CYCLES_2,
  parameter [31:0] PERIOD_CYCLES_3 = `PERIOD_CYCLES_3,
  parameter [31:0] RESET_PULSE_CYCLES = `RESET_PULSE_CYCLES
) (
  input wire CLOCK,
  input wire RST_N,
  input wire [7:0] IO_ADDR,
  input wire [7:0] IO_WDATA,
  input wire IO_WR,
  input wire IO_RD,
  output reg [7:0] IO_RDATA,
  input wire HALT_N,
  input wire RESET_WIRED,
  output reg TIMEOUT_OUTPUT_N,
  output reg CPU_CLK_EN,
  output reg PIO_CLK_EN,
  output reg SIO_CLK_EN,
  output reg CTC_CLK_EN,
  output reg CLKOUT_EN,
  output reg OSC_EN,
  output reg SUPERVISION_CLK_EN
);

  function [31:0] period_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: period_limit = PERIOD_CYCLES_0;
        2'h1: period_limit = PERIOD_CYCLES_1;
        2'h2: period_limit = PERIOD_CYCLES_2;
        default: period_limit = PERIOD_CYCLES_3;
      endcase
    end
  endfunction

  // Key arming states: at most one key is armed at a time
  localparam [1:0] ARM_NONE = 2'b00;
  localparam [1:0] ARM_DISABLE = 2'b01;
  localparam [1:0] ARM_MODE = 2'b10;

  reg enable_q;
  reg enable_d;
  reg [1:0] period_q;
  reg [1:0] period_d;
  reg [1:0] sleep_q;
  reg [1:0] sleep_d;
  reg [1:0] arm_q;
  reg [1:0] arm_d;
  reg [31:0] count_q;
  reg [31:0] count_d;
  reg [31:0] pulse_q;
  reg [31:0] pulse_d;
  reg expired_q;
  reg expired_d;
  reg [7:0] rdata_d;
  reg wired_meta_q;
  reg wired_q;

  wire write_master = IO_WR & (IO_ADDR == `ADDR_MASTER_CONTROL);
  wire write_key = IO_WR & (IO_ADDR == `ADDR_KEY_COMMAND);
  wire key_disable = write_key & (IO_WDATA == `KEY_DISABLE);
  wire key_mode = write_key & (IO_WDATA == `KEY_MODE_CHANGE);
  wire key_clear = write_key & (IO_WDATA == `KEY_CLEAR);
  wire halted = ~HALT_N;
  wire suspend = halted & (sleep_q != `MODE_RUN);
  wire count_run = enable_q & ~suspend;
  wire [31:0] limit = period_limit(period_q);
  wire expire = count_run & ~expired_q & (count_q >= limit - 32'h0000_0001);
  wire pulse_done = expired_q & wired_q & (pulse_q >= RESET_PULSE_CYCLES - 32'h0000_0001);

  // Strap from a pin: two flops before use
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wired_meta_q <= 1'b0;
      wired_q <= 1'b0;
    end else begin
      wired_meta_q <= RESET_WIRED;
      wired_q <= wired_meta_q;
    end
  end

  // Key arming and master control fields, next values
  always @* begin
    enable_d = enable_q;
    period_d = period_q;
    sleep_d = sleep_q;
    arm_d = arm_q;
    if (write_master) begin
      period_d = IO_WDATA[`PERIOD_HI:`PERIOD_LO];
      // Mode field is taken only under the mode key
      case (arm_q)
        ARM_MODE: begin
          sleep_d = IO_WDATA[`SLEEP_HI:`SLEEP_LO];
        end
        default: begin
          sleep_d = sleep_q;
        end
      endcase
      if (IO_WDATA[`ENABLE_BIT]) begin
        enable_d = 1'b1;
        arm_d = ARM_NONE;
      end else if (enable_q) begin
        arm_d = ARM_DISABLE;
      end else begin
        arm_d = ARM_NONE;
      end
    end else if (write_key) begin
      // Disable key counts only right after the master write
      case (arm_q)
        ARM_DISABLE: begin
          if (key_disable) begin
            enable_d = 1'b0;
          end
        end
        default: begin
          enable_d = enable_q;
        end
      endcase
      // Any key write re-decides the arming
      if (key_mode) begin
        arm_d = ARM_MODE;
      end else begin
        arm_d = ARM_NONE;
      end
    end
  end

  // Master control fields and the key arming state
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      enable_q <= `ENABLE_RESET;
      period_q <= `PERIOD_RESET;
      sleep_q <= `SLEEP_RESET;
      arm_q <= ARM_NONE;
    end else begin
      enable_q <= enable_d;
      period_q <= period_d;
      sleep_q <= sleep_d;
      arm_q <= arm_d;
    end
  end

  // Interval counter and timeout state, next values
  always @* begin
    count_d = count_q;
    pulse_d = pulse_q;
    expired_d = expired_q;
    // Disabled timer: nothing pending, count parked at zero
    if (!enable_q) begin
      count_d = 32'h0000_0000;
      pulse_d = 32'h0000_0000;
      expired_d = 1'b0;
    end else if (expire) begin
      // Expiry beats a clear in the same cycle
      expired_d = 1'b1;
      count_d = 32'h0000_0000;
      pulse_d = 32'h0000_0000;
    end else if (pulse_done || key_clear) begin
      expired_d = 1'b0;
      count_d = 32'h0000_0000;
      pulse_d = 32'h0000_0000;
    end else if (expired_q) begin
      // Pulse mode: hold low for the pulse length
      if (wired_q) begin
        pulse_d = pulse_q + 32'h0000_0001;
      end
    end else if (count_run) begin
      count_d = count_q + 32'h0000_0001;
    end
  end

  // Interval counter registers
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      count_q <= 32'h0000_0000;
      pulse_q <= 32'h0000_0000;
      expired_q <= 1'b0;
    end else begin
      count_q <= count_d;
      pulse_q <= pulse_d;
      expired_q <= expired_d;
    end
  end

  // Read data, next value
  always @* begin
    rdata_d = IO_RDATA;
    if (IO_RD) begin
      case (IO_ADDR)
        `ADDR_MASTER_CONTROL: begin
          rdata_d = {enable_q, period_q, `RESERVED_READ, sleep_q};
        end
        `ADDR_KEY_COMMAND: begin
          rdata_d = `KEY_READ;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // Outputs: read data, timeout pin, clock gates
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      IO_RDATA <= 8'h00;
      TIMEOUT_OUTPUT_N <= 1'b1;
      CPU_CLK_EN <= 1'b1;
      PIO_CLK_EN <= 1'b1;
      SIO_CLK_EN <= 1'b1;
      CTC_CLK_EN <= 1'b1;
      CLKOUT_EN <= 1'b1;
      OSC_EN <= 1'b1;
      SUPERVISION_CLK_EN <= 1'b1;
    end else begin
      IO_RDATA <= rdata_d;
      TIMEOUT_OUTPUT_N <= ~expired_q;
      if (!halted) begin
        CPU_CLK_EN <= 1'b1;
        PIO_CLK_EN <= 1'b1;
        SIO_CLK_EN <= 1'b1;
        CTC_CLK_EN <= 1'b1;
        CLKOUT_EN <= 1'b1;
        OSC_EN <= 1'b1;
        SUPERVISION_CLK_EN <= 1'b1;
      end else begin
        case (sleep_q)
          `MODE_FIRST_IDLE_MODE: begin
            CPU_CLK_EN <= 1'b0;
            PIO_CLK_EN <= 1'b0;
            SIO_CLK_EN <= 1'b0;
            CTC_CLK_EN <= 1'b0;
            CLKOUT_EN <= 1'b0;
            OSC_EN <= 1'b1;
            SUPERVISION_CLK_EN <= 1'b0;
          end
          `MODE_SECOND_IDLE_MODE: begin
            CPU_CLK_EN <= 1'b0;
            PIO_CLK_EN <= 1'b0;
            SIO_CLK_EN <= 1'b0;
            CTC_CLK_EN <= 1'b1;
            CLKOUT_EN <= 1'b1;
            OSC_EN <= 1'b1;
            SUPERVISION_CLK_EN <= 1'b0;
          end
          `MODE_STOP: begin
            CPU_CLK_EN <= 1'b0;
            PIO_CLK_EN <= 1'b0;
            SIO_CLK_EN <= 1'b0;
            CTC_CLK_EN <= 1'b0;
            CLKOUT_EN <= 1'b0;
            OSC_EN <= 1'b0;
            SUPERVISION_CLK_EN <= 1'b0;
          end
          default: begin
            CPU_CLK_EN <= 1'b1;
            PIO_CLK_EN <= 1'b1;
            SIO_CLK_EN <= 1'b1;
            CTC_CLK_EN <= 1'b1;
            CLKOUT_EN <= 1'b1;
            OSC_EN <= 1'b1;
            SUPERVISION_CLK_EN <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // watchdog_powerdown_keys
`default_nettype wire

//--- sim/watchdog_powerdown_keys_properties.sv
/* Port checker for the supervision timer.
   Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module watchdog_powerdown_keys_properties (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_RDATA,
  input wire logic HALT_N,
  input wire logic RESET_WIRED,
  input wire logic TIMEOUT_OUTPUT_N,
  input wire logic CPU_CLK_EN,
  input wire logic PIO_CLK_EN,
  input wire logic SIO_CLK_EN,
  input wire logic CTC_CLK_EN,
  input wire logic CLKOUT_EN,
  input wire logic OSC_EN,
  input wire logic SUPERVISION_CLK_EN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence off_write;
    IO_WR && IO_ADDR == 8'hF0 && !IO_WDATA[7];
  endsequence
  sequence off_key;
    IO_WR && IO_ADDR == 8'hF1 && IO_WDATA == 8'h41;
  endsequence
  a_key_read_zero: assert property (
    IO_RD && IO_ADDR == 8'hF1 |=> IO_RDATA == 8'h00) else $error("key register read not zero");
  a_unmapped_read: assert property (
    IO_RD && IO_ADDR != 8'hF0 && IO_ADDR != 8'hF1 |=> IO_RDATA == 8'h00) else $error("unmapped read not zero");
  a_reserved_bits: assert property (
    IO_RD && IO_ADDR == 8'hF0 |=> IO_RDATA[4:2] == 3'h3) else $error("reserved bits wrong");
  a_rdata_hold: assert property (
    !IO_RD |=> $stable(IO_RDATA)) else $error("read data moved without read");
  a_disable_pair: assert property (
    off_write ##1 !IO_WR ##1 off_key |-> ##2 TIMEOUT_OUTPUT_N [*8]) else $error("timeout after disable");
  a_latched_hold: assert property (
    !TIMEOUT_OUTPUT_N && !RESET_WIRED && !$past(RESET_WIRED, 3) && !IO_WR && !$past(IO_WR)
    |=> !TIMEOUT_OUTPUT_N) else $error("latched timeout released");
  a_gates_halted: assert property (
    !CPU_CLK_EN |-> !PIO_CLK_EN && !SIO_CLK_EN && !SUPERVISION_CLK_EN) else $error("gate set wrong");
  a_gate_cause: assert property (
    !SUPERVISION_CLK_EN |-> $past(!HALT_N)) else $error("gate off without halt");
  a_ctc_clkout: assert property (
    CTC_CLK_EN == CLKOUT_EN && (OSC_EN || !CTC_CLK_EN)) else $error("counter gate wrong");
endmodule // watchdog_powerdown_keys_properties
bind watchdog_powerdown_keys watchdog_powerdown_keys_properties chk_i (.CLOCK(CLOCK), .RST_N(RST_N),
  .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA),
  .HALT_N(HALT_N), .RESET_WIRED(RESET_WIRED), .TIMEOUT_OUTPUT_N(TIMEOUT_OUTPUT_N),
  .CPU_CLK_EN(CPU_CLK_EN), .PIO_CLK_EN(PIO_CLK_EN), .SIO_CLK_EN(SIO_CLK_EN), .CTC_CLK_EN(CTC_CLK_EN),
  .CLKOUT_EN(CLKOUT_EN), .OSC_EN(OSC_EN), .SUPERVISION_CLK_EN(SUPERVISION_CLK_EN));
`default_nettype wire

//--- sim/tb_watchdog_powerdown_keys.sv
/* Bench: register, key, timeout and halt tests of the supervision timer.
   Drives the strap low for latched timeout output, then high for the reset pulse. */
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_powerdown_keys;
  logic CLOCK = 0, RST_N = 0, IO_WR = 0, IO_RD = 0, HALT_N = 1, RESET_WIRED = 0;
  logic [7:0] IO_ADDR = 8'h00, IO_WDATA = 8'h00;
  wire [7:0] IO_RDATA;
  wire TIMEOUT_OUTPUT_N, CPU_CLK_EN, PIO_CLK_EN, SIO_CLK_EN, CTC_CLK_EN, CLKOUT_EN, OSC_EN, SUPERVISION_CLK_EN;
  int n_mismatch = 0, check_count = 0, i, k;
  always #2.5 CLOCK = ~CLOCK;
  watchdog_powerdown_keys #(.PERIOD_CYCLES_0(8), .PERIOD_CYCLES_1(16), .PERIOD_CYCLES_2(32),
    .PERIOD_CYCLES_3(64), .RESET_PULSE_CYCLES(4)) dut (.CLOCK(CLOCK), .RST_N(RST_N),
    .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA),
    .HALT_N(HALT_N), .RESET_WIRED(RESET_WIRED), .TIMEOUT_OUTPUT_N(TIMEOUT_OUTPUT_N),
    .CPU_CLK_EN(CPU_CLK_EN), .PIO_CLK_EN(PIO_CLK_EN), .SIO_CLK_EN(SIO_CLK_EN), .CTC_CLK_EN(CTC_CLK_EN),
    .CLKOUT_EN(CLKOUT_EN), .OSC_EN(OSC_EN), .SUPERVISION_CLK_EN(SUPERVISION_CLK_EN));
  task wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    IO_WR <= 1'b1;
    IO_ADDR <= a;
    IO_WDATA <= d;
    @(posedge CLOCK);
    IO_WR <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLOCK);
    IO_RD <= 1'b1;
    IO_ADDR <= a;
    @(posedge CLOCK);
    IO_RD <= 1'b0;
    @(posedge CLOCK);
    chk(IO_RDATA, exp);
  endtask
  // Cycles until timeout goes low, 40 at most
  task wait_low;
    k = 0;
    while (TIMEOUT_OUTPUT_N !== 1'b0 && k < 40) begin
      @(posedge CLOCK);
      #1;
      k++;
    end
  endtask
  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge CLOCK);
    RST_N <= 1'b1;
    rd(8'hF0, 8'hEF);
    rd(8'hF1, 8'h00);
    rd(8'h42, 8'h00);
    wr(8'hF0, 8'hEC);
    rd(8'hF0, 8'hEF);
    for (i = 0; i < 4; i++) begin
      wr(8'hF1, 8'hDB);
      wr(8'hF0, 8'h8C | i[7:0]);
      rd(8'hF0, 8'h8C | i[7:0]);
    end
    wr(8'hF1, 8'hDB);
    wr(8'hF1, 8'h55);
    wr(8'hF0, 8'h8D);
    rd(8'hF0, 8'h8F);
    wr(8'hF1, 8'hDB);
    wr(8'hF0, 8'h8D);
    rd(8'hF0, 8'h8D);
    wr(8'hF1, 8'h03);
    repeat (2) @(posedge CLOCK);
    #1;
    chk(TIMEOUT_OUTPUT_N, 8'h01);
    wait_low;
    chk(8'(k > 4 && k < 11), 8'h01);
    repeat (10) @(posedge CLOCK);
    #1;
    chk(TIMEOUT_OUTPUT_N, 8'h00);
    wr(8'hF1, 8'h03);
    HALT_N <= 1'b0;
    repeat (30) @(posedge CLOCK);
    #1;
    chk(TIMEOUT_OUTPUT_N, 8'h01);
    chk({1'b0, CPU_CLK_EN, PIO_CLK_EN, SIO_CLK_EN, CTC_CLK_EN, CLKOUT_EN, OSC_EN, SUPERVISION_CLK_EN}, 8'h0E);
    @(posedge CLOCK);
    HALT_N <= 1'b1;
    wr(8'hF0, 8'h0D);
    wr(8'hF1, 8'h41);
    rd(8'hF0, 8'h0D);
    wait_low;
    chk(TIMEOUT_OUTPUT_N, 8'h01);
    wr(8'hF0, 8'h8D);
    wait_low;
    chk(TIMEOUT_OUTPUT_N, 8'h00);
    @(posedge CLOCK);
    RESET_WIRED <= 1'b1;
    repeat (8) @(posedge CLOCK);
    #1;
    chk(TIMEOUT_OUTPUT_N, 8'h01);
    wait_low;
    chk(8'(k > 4 && k < 11), 8'h01);
    wrap_up;
  end
endmodule // tb_watchdog_powerdown_keys
`default_nettype wire
